/* src/etl_tx_launch.v */
// transmit launch engine: register slave, buffer fetch, pad/crc/oversize policy, status vector write-back
// assumes buffer arbiter, phy byte strobe and dma busy all run on clk_sys
`timescale 1ns/10ps
`default_nettype none
`include "etl_defs.vh"

module etl_tx_launch #(
  parameter ADDR_W = 13
)
(
  // clock and reset
  input  wire              clk_sys,
  input  wire              rst,
  // wishbone slave
  input  wire              wbCyc,
  input  wire              wbStb,
  input  wire              wbWe,
  input  wire [7:0]        wbAdr,
  input  wire [3:0]        wbSel,
  input  wire [31:0]       wbDatI,
  output reg  [31:0]       wbDatO_ff,
  output reg               wbAck_ff,
  // shared buffer arbiter channel
  output reg               memReq_ff,
  output reg               memWe_ff,
  output reg  [ADDR_W-1:0] memAddr_ff,
  output reg  [7:0]        memWdata_ff,
  input  wire              memAck,
  input  wire [7:0]        memRdata,
  // dma engine
  input  wire              dmaBusy,
  output reg               dmaStart_ff,
  // phy byte stream
  output reg  [7:0]        txData_ff,
  output reg               txValid_ff,
  input  wire              txReady,
  // interrupt
  output reg               irq_ff
);

  localparam S_IDLE  = 8'h01;
  localparam S_WAIT  = 8'h02;
  localparam S_CTRL  = 8'h04;
  localparam S_FETCH = 8'h08;
  localparam S_SEND  = 8'h10;
  localparam S_CRC   = 8'h20;
  localparam S_TSV   = 8'h40;
  localparam S_FIN   = 8'h80;

  //////////////////////////////////////////////////////////////////////////////
  // state
  reg  [7:0]        state_ff;
  reg  [7:0]        nxt_state;
  reg               txReq_ff;
  reg               dmaPend_ff;
  reg               doneFlag_ff;
  reg               bufErr_ff;
  reg               doneEn_ff;
  reg               modEn_ff;
  reg               abortStat_ff;
  reg  [ADDR_W-1:0] txStart_ff;
  reg  [ADDR_W-1:0] txEnd_ff;
  reg  [7:0]        macCfg_ff;
  reg  [15:0]       maxFl_ff;
  reg  [3:0]        pktCtrl_ff;
  reg  [ADDR_W-1:0] rdAddr_ff;
  reg  [15:0]       count_ff;
  reg  [31:0]       crc_ff;
  reg  [31:0]       fcs_ff;
  reg  [1:0]        crcIdx_ff;
  reg  [2:0]        tsvIdx_ff;
  reg               started_ff;
  reg               aborted_ff;
  reg               underrun_ff;
  reg               giant_ff;
  reg               crcErr_ff;
  reg               mcast_ff;
  reg               bcast_ff;
  reg  [31:0]       rdData;

  wire [31:0]       crcNext;
  wire              wbReq    = wbCyc && wbStb && !wbAck_ff;
  wire              wbWr     = wbReq && wbWe;
  wire              memDone  = memReq_ff && memAck;
  wire              take     = txValid_ff && txReady;
  wire              cancel   = !txReq_ff;
  wire [15:0]       countInc = count_ff + 16'h0001;

  // per-packet bits win only under override
  wire              override = pktCtrl_ff[`ETL_PKT_OVERRIDE];
  wire              useHuge  = override ? pktCtrl_ff[`ETL_PKT_HUGE] : macCfg_ff[`ETL_CFG_HUGE];
  wire              usePad   = override ? pktCtrl_ff[`ETL_PKT_PAD]  : macCfg_ff[`ETL_CFG_PAD];
  wire              useCrc   = override ? pktCtrl_ff[`ETL_PKT_CRC]  : macCfg_ff[`ETL_CFG_CRC];

  wire              moreData = rdAddr_ff != txEnd_ff;
  wire              needPad  = usePad && (countInc < `ETL_MIN_FRAME);
  wire              moreAny  = moreData || needPad || useCrc;
  wire              isGiant  = (countInc == maxFl_ff) && moreAny && !useHuge;

  wire [ADDR_W-1:0] rdAddrInc = rdAddr_ff + {{(ADDR_W-1){1'b0}}, 1'b1};
  wire [ADDR_W-1:0] tsvAddr   = txEnd_ff + {{(ADDR_W-3){1'b0}}, tsvIdx_ff} + {{(ADDR_W-1){1'b0}}, 1'b1};

  // status vector, bits laid out as stored, low byte first in memory
  wire [55:0]       tsv = {8'h00, count_ff, underrun_ff, giant_ff, 4'h0, bcast_ff, mcast_ff,
                           !aborted_ff, 2'b00, crcErr_ff, 4'h0, count_ff};
  wire [7:0]        tsvByte = tsv[{tsvIdx_ff, 3'b000} +: 8];

  etl_crc32 u_crc
  (
    .crcIn  (crc_ff),
    .dataIn (txData_ff),
    .crcOut (crcNext)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register read mux
  always @*
  begin
    rdData = 32'h00000000;
    case (wbAdr)
      `ETL_REG_CTRL:
      begin
        rdData[`ETL_CTRL_TXREQ] = txReq_ff;
        rdData[`ETL_CTRL_DMA_START] = dmaPend_ff;
      end
      `ETL_REG_FLAGS:
      begin
        rdData[`ETL_FLAG_TXDONE] = doneFlag_ff;
        rdData[`ETL_FLAG_BUFERR] = bufErr_ff;
      end
      `ETL_REG_ENABLES:
      begin
        rdData[`ETL_EN_TXDONE] = doneEn_ff;
        rdData[`ETL_EN_MODULE] = modEn_ff;
      end
      `ETL_REG_TXSTAT:
      begin
        rdData[`ETL_STAT_BUFERR] = bufErr_ff;
        rdData[`ETL_STAT_ABORT]  = abortStat_ff;
        rdData[`ETL_STAT_BUSY]   = !state_ff[0];
      end
      `ETL_REG_TXSTART: rdData[ADDR_W-1:0] = txStart_ff;
      `ETL_REG_TXEND:   rdData[ADDR_W-1:0] = txEnd_ff;
      `ETL_REG_MACCFG:  rdData[7:0]        = macCfg_ff;
      `ETL_REG_MAXFL:   rdData[15:0]       = maxFl_ff;
      default:          rdData = 32'h00000000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:  if (txReq_ff) nxt_state = S_WAIT;
      S_WAIT:
      begin
        if (cancel)
          nxt_state = S_TSV;
        else if (!dmaBusy && !dmaStart_ff)
          nxt_state = S_CTRL;
      end
      S_CTRL:  if (memDone) nxt_state = cancel ? S_TSV : S_FETCH;
      S_FETCH: if (memDone) nxt_state = (cancel || underrun_ff) ? S_TSV : S_SEND;
      S_SEND:
      begin
        if (cancel || (take && isGiant))
          nxt_state = S_TSV;
        else if (take && moreData)
          nxt_state = S_FETCH;
        else if (take && !needPad)
          nxt_state = useCrc ? S_CRC : S_TSV;
      end
      S_CRC:   if (cancel || (take && crcIdx_ff == `ETL_CRC_LAST)) nxt_state = S_TSV;
      S_TSV:   if (memDone && tsvIdx_ff == `ETL_TSV_LAST) nxt_state = S_FIN;
      S_FIN:   nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers, bus writes and engine actions; engine assignments come last so they win
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_ff     <= S_IDLE;
      wbAck_ff     <= 1'b0;
      wbDatO_ff    <= 32'h00000000;
      memReq_ff    <= 1'b0;
      memWe_ff     <= 1'b0;
      memAddr_ff   <= {ADDR_W{1'b0}};
      memWdata_ff  <= 8'h00;
      dmaStart_ff  <= 1'b0;
      txData_ff    <= 8'h00;
      txValid_ff   <= 1'b0;
      irq_ff       <= 1'b0;
      txReq_ff     <= 1'b0;
      dmaPend_ff   <= 1'b0;
      doneFlag_ff  <= 1'b0;
      bufErr_ff    <= 1'b0;
      doneEn_ff    <= 1'b0;
      modEn_ff     <= 1'b0;
      abortStat_ff <= 1'b0;
      txStart_ff   <= {ADDR_W{1'b0}};
      txEnd_ff     <= {ADDR_W{1'b0}};
      macCfg_ff    <= `ETL_MACCFG_RST;
      maxFl_ff     <= `ETL_MAXFL_RST;
      pktCtrl_ff   <= 4'h0;
      rdAddr_ff    <= {ADDR_W{1'b0}};
      count_ff     <= 16'h0000;
      crc_ff       <= `ETL_CRC_INIT;
      fcs_ff       <= 32'h00000000;
      crcIdx_ff    <= 2'b00;
      tsvIdx_ff    <= 3'h0;
      started_ff   <= 1'b0;
      aborted_ff   <= 1'b0;
      underrun_ff  <= 1'b0;
      giant_ff     <= 1'b0;
      crcErr_ff    <= 1'b0;
      mcast_ff     <= 1'b0;
      bcast_ff     <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      wbAck_ff    <= wbReq;
      dmaStart_ff <= 1'b0;
      irq_ff      <= doneFlag_ff && doneEn_ff && modEn_ff;
      if (wbReq && !wbWe)
        wbDatO_ff <= rdData;

      // bus writes; pointers are software's to keep still during a frame
      if (wbWr && wbSel[0])
      begin
        case (wbAdr)
          `ETL_REG_CTRL:
          begin
            txReq_ff <= wbDatI[`ETL_CTRL_TXREQ];
            if (wbDatI[`ETL_CTRL_DMA_START])
              dmaPend_ff <= 1'b1;
          end
          `ETL_REG_FLAGS:
          begin
            if (wbDatI[`ETL_FLAG_TXDONE])
              doneFlag_ff <= 1'b0;
            if (wbDatI[`ETL_FLAG_BUFERR])
              bufErr_ff <= 1'b0;
          end
          `ETL_REG_ENABLES:
          begin
            doneEn_ff <= wbDatI[`ETL_EN_TXDONE];
            modEn_ff  <= wbDatI[`ETL_EN_MODULE];
          end
          `ETL_REG_TXSTART: txStart_ff[7:0] <= wbDatI[7:0];
          `ETL_REG_TXEND:   txEnd_ff[7:0]   <= wbDatI[7:0];
          `ETL_REG_MACCFG:  macCfg_ff       <= wbDatI[7:0];
          `ETL_REG_MAXFL:   maxFl_ff[7:0]   <= wbDatI[7:0];
          default:          ;
        endcase
      end
      if (wbWr && wbSel[1])
      begin
        case (wbAdr)
          `ETL_REG_TXSTART: txStart_ff[ADDR_W-1:8] <= wbDatI[ADDR_W-1:8];
          `ETL_REG_TXEND:   txEnd_ff[ADDR_W-1:8]   <= wbDatI[ADDR_W-1:8];
          `ETL_REG_MAXFL:   maxFl_ff[15:8]         <= wbDatI[15:8];
          default:          ;
        endcase
      end

      // dma is held back while a transmit request stands
      if (dmaPend_ff && !txReq_ff && !dmaBusy && state_ff == S_IDLE)
      begin
        dmaStart_ff <= 1'b1;
        dmaPend_ff  <= 1'b0;
      end

      case (state_ff)
        S_IDLE:
        begin
          count_ff    <= 16'h0000;
          crc_ff      <= `ETL_CRC_INIT;
          tsvIdx_ff   <= 3'h0;
          started_ff  <= 1'b0;
          aborted_ff  <= 1'b1;
          underrun_ff <= 1'b0;
          giant_ff    <= 1'b0;
          crcErr_ff   <= 1'b0;
          mcast_ff    <= 1'b0;
          bcast_ff    <= 1'b1;
        end
        S_WAIT:
        begin
          if (!cancel && !dmaBusy && !dmaStart_ff)
          begin
            memReq_ff  <= 1'b1;
            memWe_ff   <= 1'b0;
            memAddr_ff <= txStart_ff;
          end
        end
        S_CTRL:
        begin
          if (memDone)
          begin
            pktCtrl_ff <= memRdata[3:0];
            rdAddr_ff  <= txStart_ff + {{(ADDR_W-1){1'b0}}, 1'b1};
            memAddr_ff <= txStart_ff + {{(ADDR_W-1){1'b0}}, 1'b1};
            memReq_ff  <= !cancel;
          end
        end
        S_FETCH:
        begin
          // the phy asked for a byte the buffer could not deliver in time
          if (txReady && started_ff && !memDone)
            underrun_ff <= 1'b1;
          if (memDone)
          begin
            memReq_ff  <= 1'b0;
            txData_ff  <= memRdata;
            txValid_ff <= !(cancel || underrun_ff);
          end
        end
        S_SEND:
        begin
          if (cancel)
          begin
            // a byte the phy takes in the cancel cycle still counts
            txValid_ff <= 1'b0;
            if (take)
              count_ff <= countInc;
          end
          else if (take)
          begin
            count_ff   <= countInc;
            crc_ff     <= crcNext;
            started_ff <= 1'b1;
            txValid_ff <= 1'b0;
            if (count_ff == 16'h0000)
              mcast_ff <= txData_ff[0];
            if (count_ff < 16'h0006 && txData_ff != 8'hff)
              bcast_ff <= 1'b0;
            if (isGiant)
              giant_ff <= 1'b1;
            else if (moreData)
            begin
              rdAddr_ff  <= rdAddrInc;
              memAddr_ff <= rdAddrInc;
              memReq_ff  <= 1'b1;
            end
            else if (needPad)
            begin
              txData_ff  <= 8'h00;
              txValid_ff <= 1'b1;
            end
            else if (useCrc)
            begin
              fcs_ff     <= ~crcNext;
              txData_ff  <= ~crcNext[7:0];
              txValid_ff <= 1'b1;
              crcIdx_ff  <= 2'b00;
              aborted_ff <= 1'b0;
            end
            else
            begin
              // supplied frame carries its own crc: the whole run must leave the residue
              crcErr_ff  <= crcNext != `ETL_CRC_RESIDUE;
              aborted_ff <= 1'b0;
            end
          end
        end
        S_CRC:
        begin
          if (cancel)
          begin
            txValid_ff <= 1'b0;
            aborted_ff <= 1'b1;
            if (take)
              count_ff <= countInc;
          end
          else if (take)
          begin
            count_ff  <= countInc;
            crcIdx_ff <= crcIdx_ff + 2'b01;
            if (crcIdx_ff == `ETL_CRC_LAST)
              txValid_ff <= 1'b0;
            else
              txData_ff <= fcs_ff[{crcIdx_ff + 2'b01, 3'b000} +: 8];
          end
        end
        S_TSV:
        begin
          if (!memReq_ff)
          begin
            memReq_ff   <= 1'b1;
            memWe_ff    <= 1'b1;
            memAddr_ff  <= tsvAddr;
            memWdata_ff <= tsvByte;
          end
          else if (memDone)
          begin
            memReq_ff <= 1'b0;
            memWe_ff  <= 1'b0;
            tsvIdx_ff <= tsvIdx_ff + 3'h1;
          end
        end
        S_FIN:
        begin
          // pointer registers are never touched here
          txReq_ff     <= 1'b0;
          doneFlag_ff  <= 1'b1;
          abortStat_ff <= aborted_ff;
          if (underrun_ff)
            bufErr_ff <= 1'b1;
        end
        default: ;
      endcase
    end
  end

endmodule
`default_nettype wire

/* src/etl_defs.vh */
// constants for the transmit launch path: register map, field positions, reset values, frame figures
// assumes a 32-bit classic wishbone register bus and an 8-bit shared buffer port
//
// Summary of operation
// - control byte: upper four bits unused, zero
// - override and oversize one: send whole frame
// - oversize zero: abort at maximum frame length
// - pad bit: zero-pad short frames to 60
// - crc bit one: compute and append crc
// - crc bit zero: check last four bytes
// - override clear: use global mac settings
// - transmit waits for running dma to finish
// - dma start waits until request clears
// - clearing request cancels as an abort
// - device clears request when frame ends
// - seven status bytes after end pointer
// - set done flag, raise interrupt if enabled
// - start and end pointers left unchanged
// - abort status bit set on failure
// - status fields stored low byte first
// - status bit 23 only on success
// - status bit 31 flags buffer underrun
`ifndef ETL_DEFS_VH
`define ETL_DEFS_VH

// register byte offsets
`define ETL_REG_CTRL      8'h00
`define ETL_REG_FLAGS     8'h04
`define ETL_REG_ENABLES   8'h08
`define ETL_REG_TXSTAT    8'h0c
`define ETL_REG_TXSTART   8'h10
`define ETL_REG_TXEND     8'h14
`define ETL_REG_MACCFG    8'h18
`define ETL_REG_MAXFL     8'h1c

// module_control_one fields
`define ETL_CTRL_TXREQ    3
`define ETL_CTRL_DMA_START    5
// module_irq_flags fields (write one to clear)
`define ETL_FLAG_TXDONE   3
`define ETL_FLAG_BUFERR   0
// module_irq_enables fields
`define ETL_EN_TXDONE     3
`define ETL_EN_MODULE     7
// status fields
`define ETL_STAT_BUFERR   0
`define ETL_STAT_ABORT    1
`define ETL_STAT_BUSY     2
// mac_config_three fields
`define ETL_CFG_HUGE      2
`define ETL_CFG_CRC       4
`define ETL_CFG_PAD       5
// per-packet control byte fields
`define ETL_PKT_OVERRIDE  0
`define ETL_PKT_CRC       1
`define ETL_PKT_PAD       2
`define ETL_PKT_HUGE      3

// reset values
`define ETL_MACCFG_RST    8'h00
`define ETL_MAXFL_RST     16'h05ee

// frame figures
`define ETL_MIN_FRAME     16'h003c
`define ETL_TSV_LAST      3'h6
`define ETL_CRC_LAST      2'h3
`define ETL_CRC_INIT      32'hffffffff
`define ETL_CRC_POLY      32'hedb88320
`define ETL_CRC_RESIDUE   32'hdebb20e3

`endif

/* src/etl_crc32.v */
// byte-wide update of the reflected ethernet crc register
// assumes the caller holds the register and feeds bytes lsb first
`timescale 1ns/10ps
`default_nettype none
`include "etl_defs.vh"

module etl_crc32
(
  // running value
  input  wire [31:0] crcIn,
  // byte to fold in
  input  wire [7:0]  dataIn,
  // updated value
  output reg  [31:0] crcOut
);

  integer i;

  always @*
  begin
    crcOut = crcIn;
    for (i = 0; i < 8; i = i + 1)
    begin
      if (crcOut[0] ^ dataIn[i])
        crcOut = {1'b0, crcOut[31:1]} ^ `ETL_CRC_POLY;
      else
        crcOut = {1'b0, crcOut[31:1]};
    end
  end

endmodule
`default_nettype wire

/* tb/etl_chk.sv */
// checker on the launch engine ports
// assumes one clk_sys domain with sync rst
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////
module etl_chk #(parameter ADDR_W = 13)
(
  // clock, reset
  input wire logic              clk_sys,
  input wire logic              rst,
  // bus
  input wire logic              wbCyc,
  input wire logic              wbStb,
  input wire logic              wbAck_ff,
  // buffer
  input wire logic              memReq_ff,
  input wire logic              memWe_ff,
  input wire logic [ADDR_W-1:0] memAddr_ff,
  input wire logic              memAck,
  // dma, phy
  input wire logic              dmaBusy,
  input wire logic              dmaStart_ff,
  input wire logic [7:0]        txData_ff,
  input wire logic              txValid_ff,
  input wire logic              txReady
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // last fetch address; status writes clear it so frames never chain
  logic [ADDR_W-1:0] rdAddr_ff;
  logic              rdSeen_ff;
  always_ff @(posedge clk_sys)
  begin
    if (memReq_ff && memAck)
      rdAddr_ff <= memAddr_ff;
    if (rst || memWe_ff)
      rdSeen_ff <= 1'b0;
    else if (memReq_ff && memAck)
      rdSeen_ff <= 1'b1;
  end
  sequence s_busTake;
    wbCyc && wbStb && !wbAck_ff;
  endsequence
  sequence s_wrDone;
    memReq_ff && memWe_ff && memAck;
  endsequence
  a_ack_pulse: assert property (s_busTake |=> wbAck_ff ##1 !wbAck_ff)
    else $error("bus ack not one cycle");
  a_req_hold: assert property (memReq_ff && !memAck |=> memReq_ff && $stable(memAddr_ff) && $stable(memWe_ff))
    else $error("buffer request moved before ack");
  a_tx_hold: assert property (txValid_ff && !txReady ##1 txValid_ff |-> $stable(txData_ff))
    else $error("tx byte changed before taken");
  a_dma_wait: assert property (dmaBusy |=> !$rose(memReq_ff))
    else $error("fetch began while dma busy");
  a_dma_idle: assert property (memReq_ff || txValid_ff |-> !dmaStart_ff)
    else $error("dma launched during transmit");
  a_dma_pulse: assert property (dmaStart_ff |=> !dmaStart_ff)
    else $error("dma start longer than a pulse");
  a_fetch_order: assert property ($rose(memReq_ff) && !memWe_ff && rdSeen_ff |-> memAddr_ff == rdAddr_ff + 1'b1)
    else $error("fetch address not ascending");
  a_tsv_order: assert property (s_wrDone ##1 !memReq_ff ##1 memReq_ff && memWe_ff |-> memAddr_ff == $past(memAddr_ff, 2) + 1'b1)
    else $error("status bytes not ascending");
  a_wr_quiet: assert property (memReq_ff && memWe_ff |-> !txValid_ff)
    else $error("status write during frame");
endmodule
bind etl_tx_launch etl_chk #(.ADDR_W(ADDR_W)) u_etl_chk (.clk_sys, .rst, .wbCyc, .wbStb, .wbAck_ff,
  .memReq_ff, .memWe_ff, .memAddr_ff, .memAck, .dmaBusy, .dmaStart_ff, .txData_ff, .txValid_ff, .txReady);
`default_nettype wire

/* tb/etl_buf_phy.sv */
// partner: buffer memory behind the arbiter and a byte-paced phy
// assumes requests held until memAck, all on clk_sys
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////
module etl_buf_phy #(parameter ADDR_W = 13)
(
  // clock, reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // arbiter channel
  input  wire logic              memReq,
  input  wire logic              memWe,
  input  wire logic [ADDR_W-1:0] memAddr,
  input  wire logic [7:0]        memWdata,
  output var  logic              memAck,
  output var  logic [7:0]        memRdata,
  // phy
  input  wire logic [7:0]        txData,
  input  wire logic              txValid,
  output wire logic              txReady,
  // pacing
  input  wire logic [7:0]        ackDly,
  input  wire logic [7:0]        phyGap,
  input  wire logic              starve
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0] waitCnt;
  logic [7:0] gapCnt;
  logic [7:0] txq [$];
  // a starving phy pulls bytes whether offered or not
  assign txReady = starve || (txValid && gapCnt == 8'h00);
  always @(posedge clk_sys)
  begin
    memAck <= 1'b0;
    // read data is only valid with ack, so it keeps changing
    memRdata <= ~memRdata;
    if (rst)
    begin
      waitCnt <= 8'h00;
      gapCnt <= 8'h00;
      memRdata <= 8'h5a;
    end
    else
    begin
      if (memReq && !memAck && waitCnt < ackDly)
        waitCnt <= waitCnt + 8'h01;
      else if (memReq && !memAck)
      begin
        waitCnt <= 8'h00;
        memAck <= 1'b1;
        if (memWe)
          mem[memAddr] <= memWdata;
        else
          memRdata <= mem[memAddr];
      end
      if (txValid && txReady)
      begin
        txq.push_back(txData);
        gapCnt <= phyGap;
      end
      else if (gapCnt != 8'h00)
        gapCnt <= gapCnt - 8'h01;
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the launch engine
// assumes the partner holds buffer memory and paces the phy
`timescale 1ns/10ps
`default_nettype none
`include "etl_defs.vh"
//////////////////////////////////////////////
module testbench;
  logic        clk_sys, memReq_ff, memWe_ff, memAck, dmaStart_ff, txValid_ff, txReady, irq_ff, wbAck_ff;
  logic        rst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, dmaBusy = 1'b0, starve = 1'b0;
  logic [7:0]  wbAdr = 8'h00, ackDly = 8'h00, phyGap = 8'h00, memWdata_ff, memRdata, txData_ff;
  logic [3:0]  wbSel = 4'hf;
  logic [31:0] wbDatI = 32'h0, wbDatO_ff, q;
  logic [12:0] memAddr_ff;
  logic [55:0] tsv;
  int          error_cnt = 0, n_tests = 0, dmaCnt = 0;
  etl_tx_launch u_etl_tx_launch (.clk_sys, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatI, .wbDatO_ff,
    .wbAck_ff, .memReq_ff, .memWe_ff, .memAddr_ff, .memWdata_ff, .memAck, .memRdata, .dmaBusy,
    .dmaStart_ff, .txData_ff, .txValid_ff, .txReady, .irq_ff);
  etl_buf_phy u_etl_buf_phy (.clk_sys, .rst, .memReq(memReq_ff), .memWe(memWe_ff), .memAddr(memAddr_ff),
    .memWdata(memWdata_ff), .memAck, .memRdata, .txData(txData_ff), .txValid(txValid_ff), .txReady,
    .ackDly, .phyGap, .starve);
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (dmaStart_ff)
      dmaCnt <= dmaCnt + 1;
  //////////////////////////////////////////////
  function automatic int sz();
    return u_etl_buf_phy.txq.size();
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    wbAdr <= a;
    wbWe <= w;
    wbDatI <= d;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    do @(posedge clk_sys); while (wbAck_ff !== 1'b1);
    q = wbDatO_ff;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic launch(input logic [7:0] cb, input int n);
    u_etl_buf_phy.mem[13'h0120] = cb;
    for (int i = 1; i <= n; i++)
      u_etl_buf_phy.mem[13'h0120 + i] = 8'h10 + i[7:0];
    u_etl_buf_phy.txq.delete();
    wb(`ETL_REG_TXSTART, 1'b1, 32'h0120);
    wb(`ETL_REG_TXEND, 1'b1, 32'h0120 + n);
    wb(`ETL_REG_CTRL, 1'b1, 32'h08);
  endtask
  // ex holds the expected irq, abort status and buffer error
  task automatic finish(input int n, input logic [2:0] ex);
    q = 32'h0;
    for (int k = 0; k < 2000 && q[`ETL_FLAG_TXDONE] !== 1'b1; k++)
      wb(`ETL_REG_FLAGS, 1'b0, 32'h0);
    chk("done flag", 1, q[`ETL_FLAG_TXDONE]);
    chk("buffer error flag", ex[0], q[`ETL_FLAG_BUFERR]);
    chk("irq", ex[2], irq_ff);
    for (int i = 0; i < 7; i++)
      tsv[i*8 +: 8] = u_etl_buf_phy.mem[13'h0121 + n + i];
    chk("byte count", sz(), tsv[15:0]);
    chk("wire bytes", sz(), tsv[47:32]);
    wb(`ETL_REG_TXSTAT, 1'b0, 32'h0);
    chk("abort status", ex[1], q[`ETL_STAT_ABORT]);
    wb(`ETL_REG_CTRL, 1'b0, 32'h0);
    chk("request bit", 32'h0, q[`ETL_CTRL_TXREQ]);
    wb(`ETL_REG_TXSTART, 1'b0, 32'h0);
    chk("start pointer", 32'h0120, q);
    wb(`ETL_REG_TXEND, 1'b0, 32'h0);
    chk("end pointer", 32'h0120 + n, q);
    for (int i = 0; i < n && i < sz(); i++)
      chk("tx byte", 8'h11 + i, u_etl_buf_phy.txq[i]);
    wb(`ETL_REG_FLAGS, 1'b1, 32'h09);
  endtask
  task automatic chk_fcs(input int n);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < n; i++)
    begin
      c = c ^ u_etl_buf_phy.txq[i];
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ `ETL_CRC_POLY : c >> 1;
    end
    for (int i = 0; i < 4; i++)
      chk("fcs byte", ~c >> (8 * i) & 32'hff, u_etl_buf_phy.txq[n + i]);
  endtask
  //////////////////////////////////////////////
  task automatic t_regs;
    wb(`ETL_REG_MAXFL, 1'b0, 32'h0);
    chk("max length reset", 32'h05ee, q);
    wb(8'h40, 1'b1, 32'hff);
    wb(8'h40, 1'b0, 32'h0);
    chk("unmapped read", 32'h0, q);
    wb(`ETL_REG_ENABLES, 1'b1, 32'h88);
  endtask
  task automatic t_pad;
    phyGap <= 8'h03;
    launch(8'h07, 10);
    finish(10, 3'b100);
    chk("irq cleared", 0, irq_ff);
    chk("padded length", 64, sz());
    for (int i = 10; i < 60; i++)
      chk("pad byte", 0, u_etl_buf_phy.txq[i]);
    chk_fcs(60);
    chk("done bit", 1, tsv[23]);
    phyGap <= 8'h00;
  endtask
  task automatic t_check;
    wb(`ETL_REG_MACCFG, 1'b1, 32'h30);
    wb(`ETL_REG_ENABLES, 1'b1, 32'h80);
    launch(8'h01, 20);
    finish(20, 3'b000);
    chk("unpadded length", 20, sz());
    chk("fcs error bit", 1, tsv[20]);
    wb(`ETL_REG_MACCFG, 1'b1, 32'h10);
    wb(`ETL_REG_ENABLES, 1'b1, 32'h88);
    launch(8'h0c, 10);
    finish(10, 3'b100);
    chk("global length", 14, sz());
    chk_fcs(10);
  endtask
  task automatic t_giant;
    wb(`ETL_REG_MAXFL, 1'b1, 32'h10);
    launch(8'h03, 30);
    finish(30, 3'b110);
    chk("giant bit", 1, tsv[30]);
    chk("giant done bit", 0, tsv[23]);
    chk("giant cut", 16, sz());
    launch(8'h0b, 30);
    finish(30, 3'b100);
    chk("huge length", 34, sz());
    wb(`ETL_REG_MAXFL, 1'b1, 32'h05ee);
  endtask
  task automatic t_dma;
    dmaBusy <= 1'b1;
    launch(8'h00, 8);
    wb(`ETL_REG_CTRL, 1'b1, 32'h28);
    repeat (40) @(posedge clk_sys);
    chk("tx while dma busy", 0, sz());
    chk("dma held", 0, dmaCnt);
    wb(`ETL_REG_TXSTAT, 1'b0, 32'h0);
    chk("busy bit", 1, q[`ETL_STAT_BUSY]);
    dmaBusy <= 1'b0;
    finish(8, 3'b100);
    chk("dma launches", 1, dmaCnt);
  endtask
  task automatic t_abort;
    ackDly <= 8'h14;
    launch(8'h01, 30);
    repeat (60) @(posedge clk_sys);
    wb(`ETL_REG_CTRL, 1'b1, 32'h0);
    finish(30, 3'b110);
    chk("cancel done bit", 0, tsv[23]);
    ackDly <= 8'h06;
    starve <= 1'b1;
    launch(8'h01, 10);
    finish(10, 3'b111);
    chk("underrun bit", 1, tsv[31]);
    starve <= 1'b0;
    ackDly <= 8'h00;
  endtask
  //////////////////////////////////////////////
  task automatic summarize;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_pad();
    t_check();
    t_giant();
    t_dma();
    t_abort();
    summarize();
  end
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
